/* design/cmm_regs.vh */
// Register offsets, field positions and reset values for the comparator control block
`ifndef CMM_REGS_VH
`define CMM_REGS_VH

// ----------------------------------------
// Special-function addresses
// ----------------------------------------
`define CMM_ADDR_MODE 8'h9D
`define CMM_ADDR_INSEL 8'h9F
`define CMM_ADDR_CTRL 8'h9B

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define CMM_MODE_RISE_IE 5
`define CMM_MODE_FALL_IE 4
`define CMM_MODE_CODE_HI 1
`define CMM_MODE_CODE_LO 0
`define CMM_MODE_RESET 8'h02
`define CMM_MODE_RW_MASK 8'h33

// ----------------------------------------
// Input select register fields
// ----------------------------------------
`define CMM_INSEL_NEG_HI 7
`define CMM_INSEL_NEG_LO 4
`define CMM_INSEL_POS_HI 3
`define CMM_INSEL_POS_LO 0
`define CMM_INSEL_RESET 8'hFF
`define CMM_SEL_LAST_SMALL 4'h7
`define CMM_SEL_LAST_LARGE 4'h9

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CMM_CTRL_EN 7
`define CMM_CTRL_OUT 6
`define CMM_CTRL_RIF 5
`define CMM_CTRL_FIF 4
`define CMM_CTRL_HYS_HI 3
`define CMM_CTRL_HYS_LO 0
`define CMM_CTRL_RESET 8'h00
`define CMM_CTRL_HYS_RESET 4'h0

// ----------------------------------------
// Read data
// ----------------------------------------
`define CMM_RDATA_RESET 8'h00

`endif

/* design/cmm_input_decode.v */
// One-hot decode of a four-bit comparator input select code
`timescale 1ns/1ns
`default_nettype none
`include "cmm_regs.vh"

module cmm_input_decode #(
	parameter LARGE_VARIANT = 1
) (
	input wire [3:0] selCode,
	output reg [9:0] pinOneHot
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Codes past the last pin of this variant connect nothing
	always @* begin
		pinOneHot = 10'h000;
		if (selCode <= (LARGE_VARIANT ? `CMM_SEL_LAST_LARGE : `CMM_SEL_LAST_SMALL)) begin
			pinOneHot[selCode] = 1'b1;
		end
	end

endmodule // cmm_input_decode
`default_nettype wire

/* design/cmm_comparator_regs.v */
// Comparator mode, input select and control special-function registers
// Operation
// R01: mode bit 5 enables the rising-edge interrupt, read/write, resets to 0
// R02: mode bit 4 enables the falling-edge interrupt, read/write, resets to 0
// R03: mode bits 7:6 and 3:2 read zero, writes there ignored
// R04: mode bits 1:0 give response code to comparator, 00 fastest, reset 10
// R05: mode register decodes at address 0x9D on every register page
// R06: input select register at 0x9F on every page, resets to all ones
// R07: select bits 7:4 pick negative input pin; codes 1010-1111 connect nothing
// R08: select bits 3:0 pick positive input pin; codes 1010-1111 connect nothing
// R09: rising and falling comparator edges set sticky flags cleared by software
// R10: with enable clear, pin output is low and comparator is powered down
// R11: interrupt request is any edge flag together with its enable
`timescale 1ns/1ns
`default_nettype none
`include "cmm_regs.vh"

module cmm_comparator_regs #(
	parameter LARGE_VARIANT = 1
) (
	input wire ref_clk,
	input wire arst_n,
	input wire [7:0] sfrAddr,
	input wire sfrWrite,
	input wire sfrRead,
	input wire [7:0] sfrWdata,
	output reg [7:0] sfrRdata,
	input wire cmpOut,
	output wire cmpPowerOn,
	output wire [1:0] responseModeCode,
	output wire [3:0] hysteresisCode,
	output wire [9:0] negativeInputSelect,
	output wire [9:0] positiveInputSelect,
	output wire cmpPinOut,
	output wire cmpIrq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [7:0] mode_reg;
	reg [7:0] inSel_reg;
	reg comparatorEnable_reg;
	reg [3:0] hyst_reg;
	reg risingEdgeFlag_reg;
	reg fallingEdgeFlag_reg;
	reg cmpOutPrev_reg;
	reg [7:0] mode_next;
	reg [7:0] inSel_next;
	reg comparatorEnable_next;
	reg [3:0] hyst_next;
	reg risingEdgeFlag_next;
	reg fallingEdgeFlag_next;
	reg [7:0] rdData_next;
	wire cmpOutPrev_next;
	wire wrMode;
	wire wrInSel;
	wire wrCtrl;
	wire rdMode;
	wire rdInSel;
	wire rdCtrl;
	wire cmpOutGated;
	wire riseSeen;
	wire fallSeen;
	wire riseIrqEnable;
	wire fallIrqEnable;
	wire [7:0] modeReadback;
	wire [7:0] ctrlReadback;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Page-independent write decode
	assign wrMode = sfrWrite && (sfrAddr == `CMM_ADDR_MODE); // [R05]
	assign wrInSel = sfrWrite && (sfrAddr == `CMM_ADDR_INSEL); // [R06]
	assign wrCtrl = sfrWrite && (sfrAddr == `CMM_ADDR_CTRL);

	// Page-independent read decode
	assign rdMode = sfrRead && (sfrAddr == `CMM_ADDR_MODE); // [R05]
	assign rdInSel = sfrRead && (sfrAddr == `CMM_ADDR_INSEL); // [R06]
	assign rdCtrl = sfrRead && (sfrAddr == `CMM_ADDR_CTRL);

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	// Output seen low while powered down, so enabling on a high input reports a rise
	assign cmpOutGated = comparatorEnable_reg & cmpOut; // [R10]
	assign cmpOutPrev_next = cmpOutGated;
	assign riseSeen = comparatorEnable_reg && cmpOut && !cmpOutPrev_reg; // [R09]
	assign fallSeen = comparatorEnable_reg && !cmpOut && cmpOutPrev_reg; // [R09]

	// ----------------------------------------
	// Field views
	// ----------------------------------------
	// Stored bits as the bus and the comparator see them
	assign riseIrqEnable = mode_reg[`CMM_MODE_RISE_IE]; // [R01]
	assign fallIrqEnable = mode_reg[`CMM_MODE_FALL_IE]; // [R02]
	assign modeReadback = mode_reg & `CMM_MODE_RW_MASK; // [R03]
	assign ctrlReadback = {comparatorEnable_reg, cmpOutGated, risingEdgeFlag_reg, fallingEdgeFlag_reg, hyst_reg};

	// ----------------------------------------
	// Register next values
	// ----------------------------------------
	// Mode: only the enables and the response code are kept
	always @* begin
		mode_next = mode_reg;
		if (wrMode) begin
			mode_next = sfrWdata & `CMM_MODE_RW_MASK; // [R01] [R02] [R03] [R04]
		end
	end

	// Input select: whole byte, both nibbles
	always @* begin
		inSel_next = inSel_reg;
		if (wrInSel) begin
			inSel_next = sfrWdata; // [R06] [R07] [R08]
		end
	end

	// Control: enable and hysteresis; output state bit is read-only
	always @* begin
		comparatorEnable_next = comparatorEnable_reg;
		hyst_next = hyst_reg;
		if (wrCtrl) begin
			comparatorEnable_next = sfrWdata[`CMM_CTRL_EN]; // [R10]
			hyst_next = sfrWdata[`CMM_CTRL_HYS_HI:`CMM_CTRL_HYS_LO];
		end
	end

	// Edge flags: software write applies first, a new edge then wins over the clear
	always @* begin
		risingEdgeFlag_next = risingEdgeFlag_reg;
		fallingEdgeFlag_next = fallingEdgeFlag_reg;
		if (wrCtrl) begin
			risingEdgeFlag_next = sfrWdata[`CMM_CTRL_RIF];
			fallingEdgeFlag_next = sfrWdata[`CMM_CTRL_FIF];
		end
		if (riseSeen) begin
			risingEdgeFlag_next = 1'b1; // [R09]
		end
		if (fallSeen) begin
			fallingEdgeFlag_next = 1'b1; // [R09]
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Mode register
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg <= `CMM_MODE_RESET; // [R01] [R02] [R04]
		end else begin
			mode_reg <= mode_next;
		end
	end

	// Input select register
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			inSel_reg <= `CMM_INSEL_RESET; // [R06]
		end else begin
			inSel_reg <= inSel_next;
		end
	end

	// Control register
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			comparatorEnable_reg <= 1'b0;
			hyst_reg <= `CMM_CTRL_HYS_RESET;
		end else begin
			comparatorEnable_reg <= comparatorEnable_next;
			hyst_reg <= hyst_next;
		end
	end

	// Edge flags and previous output sample
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			risingEdgeFlag_reg <= 1'b0;
			fallingEdgeFlag_reg <= 1'b0;
			cmpOutPrev_reg <= 1'b0;
		end else begin
			risingEdgeFlag_reg <= risingEdgeFlag_next;
			fallingEdgeFlag_reg <= fallingEdgeFlag_next;
			cmpOutPrev_reg <= cmpOutPrev_next;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Read multiplexer, unmapped addresses give zero
	always @* begin
		rdData_next = `CMM_RDATA_RESET;
		if (rdMode) begin
			rdData_next = modeReadback; // [R03] [R05]
		end
		if (rdInSel) begin
			rdData_next = inSel_reg; // [R06]
		end
		if (rdCtrl) begin
			rdData_next = ctrlReadback; // [R09]
		end
	end

	// Registered answer, held until the next read strobe
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sfrRdata <= `CMM_RDATA_RESET;
		end else if (sfrRead) begin
			sfrRdata <= rdData_next;
		end
	end

	// ----------------------------------------
	// Comparator controls
	// ----------------------------------------
	// Mode code, hysteresis and power go straight to the analog core
	assign responseModeCode = mode_reg[`CMM_MODE_CODE_HI:`CMM_MODE_CODE_LO]; // [R04]
	assign hysteresisCode = hyst_reg;
	assign cmpPowerOn = comparatorEnable_reg; // [R10]
	assign cmpPinOut = cmpOutGated; // [R10]

	// Interrupt request, level while any enabled flag stands
	assign cmpIrq = (risingEdgeFlag_reg & riseIrqEnable) | (fallingEdgeFlag_reg & fallIrqEnable); // [R11]

	// ----------------------------------------
	// Input multiplexer decodes
	// ----------------------------------------
	// Negative input pins
	cmm_input_decode #(
		.LARGE_VARIANT(LARGE_VARIANT)
	) negDecode (
		.selCode(inSel_reg[`CMM_INSEL_NEG_HI:`CMM_INSEL_NEG_LO]), // [R07]
		.pinOneHot(negativeInputSelect)
	);

	// Positive input pins
	cmm_input_decode #(
		.LARGE_VARIANT(LARGE_VARIANT)
	) posDecode (
		.selCode(inSel_reg[`CMM_INSEL_POS_HI:`CMM_INSEL_POS_LO]), // [R08]
		.pinOneHot(positiveInputSelect)
	);

endmodule // cmm_comparator_regs
`default_nettype wire

/* sim/cmm_chk.sv */
// Port assertions for the comparator control registers
`timescale 1ns/1ns
`default_nettype none
module cmm_chk (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic sfrRead,
	input wire logic [7:0] sfrWdata,
	input wire logic [7:0] sfrRdata,
	input wire logic cmpPowerOn,
	input wire logic [1:0] responseModeCode,
	input wire logic [9:0] negativeInputSelect,
	input wire logic [9:0] positiveInputSelect,
	input wire logic cmpPinOut
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Expected one-hot pin select
	function automatic logic [9:0] oh(input logic [3:0] c);
		return (c < 4'hA) ? 10'h001 << c : 10'h000;
	endfunction
	AST_MODE_WR: assert property (sfrWrite && sfrAddr == 8'h9D |=> responseModeCode == $past(sfrWdata[1:0]))
		else $error("mode code not taken");
	AST_MODE_HOLD: assert property (!(sfrWrite && sfrAddr == 8'h9D) |=> $stable(responseModeCode))
		else $error("mode code moved");
	AST_NEG: assert property (sfrWrite && sfrAddr == 8'h9F |=> negativeInputSelect == oh($past(sfrWdata[7:4])))
		else $error("negative select wrong");
	AST_POS: assert property (sfrWrite && sfrAddr == 8'h9F |=> positiveInputSelect == oh($past(sfrWdata[3:0])))
		else $error("positive select wrong");
	AST_RD_ZERO: assert property (sfrRead && sfrAddr == 8'h9D |=> (sfrRdata & 8'hCC) == 8'h00)
		else $error("unused mode bits set");
	AST_PIN: assert property (!cmpPowerOn |-> !cmpPinOut)
		else $error("pin high while off");
	AST_PWR: assert property (sfrWrite && sfrAddr == 8'h9B |=> cmpPowerOn == $past(sfrWdata[7]))
		else $error("power not taken");
	AST_RST: assert property ($rose(arst_n) |-> responseModeCode == 2'h2 && negativeInputSelect == 10'h000)
		else $error("reset values wrong");
endmodule // cmm_chk
bind cmm_comparator_regs cmm_chk cmm_chk_i (.ref_clk, .arst_n, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata,
	.cmpPowerOn, .responseModeCode, .negativeInputSelect, .positiveInputSelect, .cmpPinOut);
`default_nettype wire

/* sim/cmm_cmp_model.sv */
// Behavioural comparator core behind the register block
`timescale 1ns/1ns
`default_nettype none
module cmm_cmp_model (
	input wire logic powerOn,
	input wire logic level,
	output logic cmpOut
);
	// Output sits low while powered down
	assign cmpOut = powerOn & level;
endmodule // cmm_cmp_model
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the comparator control registers
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] sfrAddr = 8'h00;
	logic [7:0] sfrWdata = 8'h00;
	logic sfrWrite = 1'b0;
	logic sfrRead = 1'b0;
	logic level = 1'b0;
	logic [7:0] sfrRdata;
	logic cmpOut, cmpPowerOn, cmpPinOut, cmpIrq;
	logic [1:0] responseModeCode;
	logic [9:0] negativeInputSelect, positiveInputSelect;
	logic [3:0] hysteresisCode;
	int errorCnt = 0;
	int nCompared = 0;
	// Rows: address, write data, expected read
	logic [23:0] rows [9] = '{24'h9DFF33, 24'h9DCC00, 24'h9D2020, 24'h9D1010, 24'h9D0101, 24'h9D0303,
		24'h9F5A5A, 24'h9F0000, 24'h9E5500};
	always #50 ref_clk = ~ref_clk;
	cmm_cmp_model cmm_cmp_model_i (.powerOn(cmpPowerOn), .level(level), .cmpOut(cmpOut));
	cmm_comparator_regs cmm_comparator_regs_i (.ref_clk, .arst_n, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata,
		.sfrRdata, .cmpOut, .cmpPowerOn, .responseModeCode, .hysteresisCode, .negativeInputSelect,
		.positiveInputSelect, .cmpPinOut, .cmpIrq);
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		nCompared++;
		if (got !== exp) begin
			errorCnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfrAddr <= a;
		sfrWdata <= d;
		sfrWrite <= 1'b1;
		@(posedge ref_clk);
		sfrWrite <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		sfrAddr <= a;
		sfrRead <= 1'b1;
		@(posedge ref_clk);
		sfrRead <= 1'b0;
		@(negedge ref_clk);
		chk(sfrRdata, exp);
	endtask
	task automatic closeOut();
		$display("compared %0d mismatches %0d", nCompared, errorCnt);
		if (errorCnt == 0 && nCompared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		rc(8'h9D, 8'h02);
		rc(8'h9F, 8'hFF);
		$display("reset test end");
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rc(rows[i][23:16], rows[i][7:0]);
		end
		chk(responseModeCode, 2'h3);
		$display("register test end");
		for (int c = 0; c < 16; c++) begin
			wr(8'h9F, {c[3:0], 4'hF - c[3:0]});
			@(negedge ref_clk);
			chk(negativeInputSelect, c < 10 ? 10'h001 << c : 10'h000);
			chk(positiveInputSelect, 15 - c < 10 ? 10'h001 << (15 - c) : 10'h000);
		end
		$display("select test end");
		wr(8'h9D, 8'h30);
		wr(8'h9B, 8'h80);
		level <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rc(8'h9B, 8'hE0);
		chk({cmpIrq, cmpPinOut}, 2'h3);
		wr(8'h9B, 8'h80);
		rc(8'h9B, 8'hC0);
		@(posedge ref_clk);
		level <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rc(8'h9B, 8'h90);
		chk(cmpIrq, 1'b1);
		wr(8'h9D, 8'h20);
		@(negedge ref_clk);
		chk(cmpIrq, 1'b0);
		wr(8'h9B, 8'h00);
		@(negedge ref_clk);
		chk({cmpPowerOn, cmpPinOut}, 2'h0);
		$display("edge test end");
		// Edge and clear in one cycle: the edge wins
		wr(8'h9B, 8'h80);
		@(posedge ref_clk);
		level <= 1'b1;
		sfrAddr <= 8'h9B;
		sfrWdata <= 8'h8A;
		sfrWrite <= 1'b1;
		@(posedge ref_clk);
		sfrWrite <= 1'b0;
		rc(8'h9B, 8'hEA);
		chk({cmpIrq, cmpPowerOn, hysteresisCode}, 6'h3A);
		$display("set-clear test end");
		// Reset in mid-run
		@(posedge ref_clk);
		arst_n <= 1'b0;
		@(negedge ref_clk);
		chk({cmpIrq, cmpPowerOn, sfrRdata}, 10'h000);
		chk(responseModeCode, 2'h2);
		chk(negativeInputSelect | positiveInputSelect, 10'h000);
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		rc(8'h9D, 8'h02);
		rc(8'h9F, 8'hFF);
		rc(8'h9B, 8'h00);
		$display("mid-run reset test end");
		closeOut();
	end
	// Hang guard
	initial begin
		#200000;
		errorCnt++;
		closeOut();
	end
endmodule // tb_top
`default_nettype wire
